// ===== rtl/acd_top.sv
/*
 * Converter control, result correction and result DMA behind an APB slave.
 * Assumes the analog core presents a left-justified raw sample on raw_sample
 * whenever a conversion ends, and a RAM port that accepts one 16-bit write
 * per valid/ready handshake.
 */
`timescale 1ns/1ps

// What this block does
// R1 - Result signed, left-justified at bit fifteen
// R2 - Period code sets sample clocks, bits
// R3 - Software writes zero to reserved bits
// R4 - Positive select routes pins, ground, references
// R5 - Software avoids reserved input codes
// R6 - No ground/half-pads in high range
// R7 - Negative select decodes same codes
// R8 - Clock bit picks 6 or 1 MHz
// R9 - Run bit starts or stops conversions
// R10 - First conversion doubled plus 21 us
// R11 - Config write while running doubles next
// R12 - Signed offset added before gain
// R13 - Offset result multiplied by gain
// R14 - Gain unsigned, one point fifteen
// R15 - DMA reset bit self-clears
// R16 - Wrap bit: stop or restart buffer
// R17 - Load starts DMA, clears on start
// R18 - Overflow when result lands while inactive
// R19 - Active status reads engine state
// R20 - Buffer size counted in results
// R21 - Saturation raises pending event
// R22 - Saturated product clamps to limits
module acd_top
    import acd_pkg::*;
#(
    parameter int WARMUP_LEN = WARMUP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [IN_CODES-1:0] positive_route,
    output logic [IN_CODES-1:0] negative_route,
    output logic slow_clock_sel,
    output logic conv_tick,
    output logic conv_busy,
    input wire logic [15:0] raw_sample,
    output logic dma_wr_valid,
    input wire logic dma_wr_ready,
    output logic [BUF_ADDR_W-1:0] dma_wr_addr,
    output logic [15:0] dma_wr_data,
    output logic saturation_pending
);

    acd_cfg_s cfg_r;
    logic [15:0] offset_r;
    logic [15:0] gain_r;
    logic [15:0] result_r;
    logic wrap_mode_sel_r;
    logic buffer_load_r;
    logic buffer_engine_active_r;
    logic buffer_overrun_r;
    logic [BUF_ADDR_W-1:0] buf_begin_r;
    logic [BUF_SIZE_W-1:0] buf_size_r;
    logic [BUF_ADDR_W-1:0] buf_cur_r;
    logic [BUF_SIZE_W-1:0] buf_count_r;
    logic [15:0] pend_data_r;
    logic pend_r;

    acd_conv_e conv_state_r;
    logic [7:0] div_cnt_r;
    logic [15:0] warm_cnt_r;
    logic [13:0] tick_cnt_r;
    logic double_r;
    logic sample_valid_r;
    logic [15:0] sample_r;
    acd_result_s corrected;

    logic wr_en;
    logic rd_hit;
    logic cfg_wr;
    logic dma_ctrl_wr;
    logic engine_reset;
    logic [13:0] conv_len;
    logic [7:0] div_top;
    logic conv_done;
    logic write_done;
    logic last_slot;

    // APB slave: zero wait states
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign cfg_wr = wr_en && paddr == CONFIG_ADDR;
    assign dma_ctrl_wr = wr_en && paddr == DMA_CTRL_ADDR;
    assign engine_reset = dma_ctrl_wr & pwdata[DMA_RST_BIT];

    always_comb begin
        rd_hit = 1'b1;
        prdata = 32'h0000_0000;
        case (paddr)
            RESULT_ADDR: prdata[15:0] = result_r; // [R1]
            CONFIG_ADDR: prdata[15:0] = cfg_r;
            OFFSET_ADDR: prdata[15:0] = offset_r;
            GAIN_ADDR: prdata[15:0] = gain_r;
            DMA_CTRL_ADDR: begin
                prdata[DMA_WRAP_BIT] = wrap_mode_sel_r;
                prdata[DMA_LOAD_BIT] = buffer_load_r;
            end
            DMA_STATE_ADDR: begin
                prdata[STAT_OVF_BIT] = buffer_overrun_r;
                prdata[STAT_ACT_BIT] = buffer_engine_active_r; // [R19]
            end
            BUF_BEGIN_ADDR: prdata[BUF_ADDR_W-1:0] = buf_begin_r;
            BUF_SIZE_ADDR: prdata[BUF_SIZE_W-1:0] = buf_size_r;
            BUF_CUR_ADDR: prdata[BUF_ADDR_W-1:0] = buf_cur_r;
            BUF_COUNT_ADDR: prdata[BUF_SIZE_W-1:0] = buf_count_r;
            default: rd_hit = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~rd_hit;

    // Configuration, offset and gain registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= acd_cfg_s'(CONFIG_RESET);
            offset_r <= OFFSET_RESET;
            gain_r <= GAIN_RESET; // [R14]
        end else if (wr_en) begin
            case (paddr)
                CONFIG_ADDR: cfg_r <= acd_cfg_s'(pwdata[15:0]);
                OFFSET_ADDR: offset_r <= pwdata[15:0];
                GAIN_ADDR: gain_r <= pwdata[15:0];
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    // Buffer placement registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_begin_r <= '0;
            buf_size_r <= '0;
        end else if (wr_en) begin
            if (paddr == BUF_BEGIN_ADDR) begin
                buf_begin_r <= {pwdata[BUF_ADDR_W-1:1], 1'b0};
            end
            if (paddr == BUF_SIZE_ADDR) begin
                buf_size_r <= pwdata[BUF_SIZE_W-1:0]; // [R20]
            end
        end
    end

    // Input routing: reserved codes leave every route open
    genvar gi;
    generate
        for (gi = 0; gi < IN_CODES; gi++) begin : g_route
            localparam logic [3:0] CODE = 4'(gi);
            localparam bit USED = (CODE <= IN_LAST_PIN) || (CODE >= IN_GROUND);
            assign positive_route[gi] = USED && cfg_r.positive_input_sel == CODE; // [R4]
            assign negative_route[gi] = USED && cfg_r.negative_input_sel == CODE; // [R7]
        end
    endgenerate

    assign slow_clock_sel = cfg_r.slow_clock_sel; // [R8]
    assign conv_busy = conv_state_r != CV_IDLE;

    // Converter clock from the bus clock
    assign div_top = cfg_r.slow_clock_sel ? 8'(SLOW_DIV - 1) : 8'(FAST_DIV - 1); // [R8]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 8'h00;
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= 1'b0;
            if (conv_state_r != CV_CONVERT || div_cnt_r >= div_top) begin
                div_cnt_r <= 8'h00;
                conv_tick <= conv_state_r == CV_CONVERT;
            end else begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
        end
    end

    // Converter clocks per conversion
    always_comb begin
        conv_len = 14'(BASE_SAMPLE_CLKS) << cfg_r.period; // [R2]
        if (double_r) begin
            conv_len = conv_len << 1; // [R10] [R11]
        end
    end

    assign conv_done = conv_state_r == CV_CONVERT && conv_tick
        && tick_cnt_r == conv_len - 14'h0001;

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_state_r <= CV_IDLE;
            warm_cnt_r <= 16'h0000;
            tick_cnt_r <= 14'h0000;
        end else begin
            case (conv_state_r)
                CV_IDLE: begin
                    warm_cnt_r <= 16'h0000;
                    tick_cnt_r <= 14'h0000;
                    if (cfg_wr && pwdata[0]) begin
                        conv_state_r <= CV_WARMUP; // [R9]
                    end
                end
                CV_WARMUP: begin
                    warm_cnt_r <= warm_cnt_r + 16'h0001;
                    if (warm_cnt_r == 16'(WARMUP_LEN - 1)) begin
                        conv_state_r <= CV_CONVERT; // [R10]
                    end
                end
                CV_CONVERT: begin
                    if (conv_done || cfg_wr) begin
                        tick_cnt_r <= 14'h0000; // [R11]
                    end else if (conv_tick) begin
                        tick_cnt_r <= tick_cnt_r + 14'h0001;
                    end
                end
                default: conv_state_r <= CV_IDLE;
            endcase
            if (cfg_wr && !pwdata[0]) begin
                conv_state_r <= CV_IDLE; // [R9]
            end
        end
    end

    // Doubled length: set on start and on any config write while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            double_r <= 1'b0;
        end else if (cfg_wr) begin
            double_r <= 1'b1; // [R10] [R11]
        end else if (conv_done) begin
            double_r <= 1'b0;
        end
    end

    // Sample capture with low bits masked to the significant width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_valid_r <= 1'b0;
            sample_r <= 16'h0000;
        end else begin
            sample_valid_r <= conv_done;
            if (conv_done) begin
                sample_r <= raw_sample & (16'hFFFF << (4'(TOP_PERIOD_SHIFT) - 4'(cfg_r.period))); // [R1] [R2]
            end
        end
    end

    acd_gain u_gain (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(sample_valid_r),
        .raw(sample_r),
        .offset(offset_r),
        .gain(gain_r),
        .result(corrected)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= 16'h0000;
            saturation_pending <= 1'b0;
        end else begin
            saturation_pending <= corrected.valid & corrected.sat; // [R21]
            if (corrected.valid) begin
                result_r <= corrected.data; // [R13]
            end
        end
    end

    // DMA control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_mode_sel_r <= 1'b0;
            buffer_load_r <= 1'b0;
        end else begin
            if (dma_ctrl_wr) begin
                wrap_mode_sel_r <= pwdata[DMA_WRAP_BIT];
            end
            if (engine_reset || buffer_load_r) begin
                buffer_load_r <= 1'b0; // [R17]
            end else if (dma_ctrl_wr && pwdata[DMA_LOAD_BIT]) begin
                buffer_load_r <= 1'b1; // [R17]
            end
        end
    end

    assign write_done = dma_wr_valid & dma_wr_ready;
    assign last_slot = buf_count_r + 13'h0001 >= buf_size_r;

    // Result DMA engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_engine_active_r <= 1'b0;
            buf_cur_r <= '0;
            buf_count_r <= '0;
        end else if (engine_reset) begin
            buffer_engine_active_r <= 1'b0; // [R15]
            buf_count_r <= '0;
        end else if (buffer_load_r) begin
            buffer_engine_active_r <= 1'b1; // [R17]
            buf_cur_r <= buf_begin_r;
            buf_count_r <= '0;
        end else if (write_done) begin
            if (!last_slot) begin
                buf_cur_r <= buf_cur_r + 14'h0002; // [R20]
                buf_count_r <= buf_count_r + 13'h0001;
            end else if (wrap_mode_sel_r) begin
                buf_cur_r <= buf_begin_r; // [R16]
                buf_count_r <= '0;
            end else begin
                buffer_engine_active_r <= 1'b0; // [R16]
                buf_count_r <= buf_count_r + 13'h0001;
            end
        end
    end

    // One pending write; a newer result replaces an unsent one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 1'b0;
            pend_data_r <= 16'h0000;
        end else begin
            if (corrected.valid && buffer_engine_active_r && !engine_reset) begin
                pend_r <= 1'b1;
                pend_data_r <= corrected.data;
            end else if (write_done || engine_reset) begin
                pend_r <= 1'b0;
            end
        end
    end

    assign dma_wr_valid = pend_r & buffer_engine_active_r;
    assign dma_wr_addr = buf_cur_r;
    assign dma_wr_data = pend_data_r;

    // Overrun is sticky; a result in the reset cycle still sets it if the engine is already inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_overrun_r <= 1'b0;
        end else if (corrected.valid && !buffer_engine_active_r) begin
            buffer_overrun_r <= 1'b1; // [R18]
        end else if (engine_reset) begin
            buffer_overrun_r <= 1'b0; // [R15] [R18]
        end
    end

endmodule : acd_top

// ===== rtl/acd_pkg.sv
/*
 * Shared constants and types for the converter control and result DMA.
 * Assumes a single 250 MHz bus clock and APB register access.
 */
package acd_pkg;

    // Clocking and conversion timing
    localparam int PCLK_MHZ = 250;
    localparam int FAST_CONV_MHZ = 6;
    localparam int SLOW_CONV_MHZ = 1;
    localparam int FAST_DIV = PCLK_MHZ / FAST_CONV_MHZ;
    localparam int SLOW_DIV = PCLK_MHZ / SLOW_CONV_MHZ;
    localparam int WARMUP_US = 21;
    localparam int WARMUP_CYCLES = WARMUP_US * PCLK_MHZ;
    localparam int BASE_SAMPLE_CLKS = 32;
    localparam int TOP_PERIOD_SHIFT = 9;

    // Register byte addresses
    localparam logic [31:0] RESULT_ADDR = 32'h4000_D000;
    localparam logic [31:0] CONFIG_ADDR = 32'h4000_D004;
    localparam logic [31:0] OFFSET_ADDR = 32'h4000_D008;
    localparam logic [31:0] GAIN_ADDR = 32'h4000_D00C;
    localparam logic [31:0] DMA_CTRL_ADDR = 32'h4000_D010;
    localparam logic [31:0] DMA_STATE_ADDR = 32'h4000_D014;
    localparam logic [31:0] BUF_BEGIN_ADDR = 32'h4000_D018;
    localparam logic [31:0] BUF_SIZE_ADDR = 32'h4000_D01C;
    localparam logic [31:0] BUF_CUR_ADDR = 32'h4000_D020;
    localparam logic [31:0] BUF_COUNT_ADDR = 32'h4000_D024;

    // Reset values
    localparam logic [15:0] CONFIG_RESET = 16'h1800;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'h8000;

    // Field positions
    localparam int DMA_LOAD_BIT = 0;
    localparam int DMA_WRAP_BIT = 1;
    localparam int DMA_RST_BIT = 4;
    localparam int STAT_ACT_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam int GAIN_POINT = 15;

    // Input select codes
    localparam int IN_CODES = 12;
    localparam logic [3:0] IN_LAST_PIN = 4'h5;
    localparam logic [3:0] IN_GROUND = 4'h8;
    localparam logic [3:0] IN_HALF_PADS = 4'hB;

    localparam int BUF_ADDR_W = 14;
    localparam int BUF_SIZE_W = 13;

    typedef struct packed {
        logic [2:0] period;
        logic [1:0] reserved_pair;
        logic [3:0] positive_input_sel;
        logic [3:0] negative_input_sel;
        logic slow_clock_sel;
        logic reserved_single;
        logic run;
    } acd_cfg_s;

    typedef struct packed {
        logic valid;
        logic sat;
        logic [15:0] data;
    } acd_result_s;

    typedef enum logic [1:0] {CV_IDLE, CV_WARMUP, CV_CONVERT} acd_conv_e;

endpackage : acd_pkg

// ===== rtl/acd_gain.sv
/*
 * Offset then gain correction of one raw result, registered output.
 * Assumes the caller holds offset and gain stable around the valid pulse.
 */
`timescale 1ns/1ps
module acd_gain
    import acd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [15:0] raw,
    input wire logic [15:0] offset,
    input wire logic [15:0] gain,
    output acd_result_s result
);

    logic signed [16:0] sum;
    logic signed [33:0] product;
    logic signed [33:0] scaled;
    logic over_hi;
    logic over_lo;

    always_comb begin
        sum = $signed({raw[15], raw}) + $signed({offset[15], offset}); // [R12]
        product = 34'(sum * $signed({1'b0, gain})); // [R13]
        scaled = product >>> GAIN_POINT; // [R14]
        over_hi = scaled > 34'sh0_0000_7FFF;
        over_lo = scaled < -34'sh0_0000_8000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= '0;
        end else begin
            result.valid <= in_valid;
            if (in_valid) begin
                result.sat <= over_hi | over_lo; // [R21]
                if (over_hi) begin
                    result.data <= 16'h7FFF; // [R22]
                end else if (over_lo) begin
                    result.data <= 16'h8000; // [R22]
                end else begin
                    result.data <= scaled[15:0];
                end
            end
        end
    end

endmodule : acd_gain

// ===== testbench/acd_assertions.sv
/*
 * Port checker for the converter control block.
 * Bound into acd_top; one pclk domain, async active-low reset.
 */
`timescale 1ns/1ps
module acd_assertions
    import acd_pkg::*;
#(
    parameter int WARMUP_LEN = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [IN_CODES-1:0] positive_route,
    input wire logic [IN_CODES-1:0] negative_route,
    input wire logic slow_clock_sel,
    input wire logic conv_tick,
    input wire logic conv_busy,
    input wire logic dma_wr_valid,
    input wire logic dma_wr_ready,
    input wire logic [BUF_ADDR_W-1:0] dma_wr_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_cfg = psel && penable && pwrite && (paddr == CONFIG_ADDR);
    wire wr_dma = psel && penable && pwrite && (paddr == DMA_CTRL_ADDR);

    function automatic logic [11:0] route(input logic [3:0] c);
        return (c < 4'hC && c != 4'h6 && c != 4'h7) ? (12'h001 << c) : 12'h000;
    endfunction : route

    property p_pos_route;
        wr_cfg |=> positive_route == route($past(pwdata[10:7]));
    endproperty
    a_pos_route: assert property (p_pos_route)
        else $error("positive route wrong after config write");
    property p_neg_route;
        wr_cfg |=> negative_route == route($past(pwdata[6:3]));
    endproperty
    a_neg_route: assert property (p_neg_route)
        else $error("negative route wrong after config write");
    property p_clk_sel;
        wr_cfg |=> slow_clock_sel == $past(pwdata[2]);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("clock select not taken from write");
    property p_stop;
        wr_cfg && !pwdata[0] |=> !conv_busy [*2];
    endproperty
    a_stop: assert property (p_stop)
        else $error("conversion still busy after stop");
    property p_warm;
        $rose(conv_busy) |-> !conv_tick [*8];
    endproperty
    a_warm: assert property (p_warm)
        else $error("converter tick during warmup");
    property p_tick_gap;
        conv_tick |=> !conv_tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("converter ticks too close");
    property p_valid_hold;
        dma_wr_valid && !dma_wr_ready && !wr_dma |=> dma_wr_valid;
    endproperty
    a_valid_hold: assert property (p_valid_hold)
        else $error("buffer write dropped before accept");
    property p_even;
        dma_wr_valid |-> !dma_wr_addr[0];
    endproperty
    a_even: assert property (p_even)
        else $error("odd buffer write address");
    property p_dma_rst;
        wr_dma && pwdata[DMA_RST_BIT] |=> !dma_wr_valid;
    endproperty
    a_dma_rst: assert property (p_dma_rst)
        else $error("buffer write pending after engine reset");
endmodule : acd_assertions

bind acd_top acd_assertions #(.WARMUP_LEN(WARMUP_LEN)) acd_assertions_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .positive_route, .negative_route,
    .slow_clock_sel, .conv_tick, .conv_busy, .dma_wr_valid, .dma_wr_ready, .dma_wr_addr);

// ===== testbench/acd_ram_model.sv
/*
 * Buffer memory model: takes one 16-bit result per valid/ready handshake.
 * Assumes valid is held until ready; slow adds wait states.
 */
`timescale 1ns/1ps
module acd_ram_model
    import acd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic wr_valid,
    input wire logic [BUF_ADDR_W-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    output logic wr_ready,
    output logic [BUF_ADDR_W-1:0] last_addr,
    output logic [15:0] last_data,
    output int n_wr
);
    logic [1:0] wait_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 2'h0;
            wr_ready <= 1'b0;
        end else begin
            wr_ready <= 1'b0;
            if (wr_valid && !wr_ready) begin
                wait_r <= wait_r + 2'h1;
                if (!slow || wait_r == 2'h3) begin
                    wr_ready <= 1'b1;
                end
            end
        end
    end
    // One result word per accepted write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_wr <= 0;
        end else if (wr_valid && wr_ready) begin
            last_addr <= wr_addr;
            last_data <= wr_data;
            n_wr <= n_wr + 1;
        end
    end
endmodule : acd_ram_model

// ===== testbench/tb.sv
/*
 * Self-checking bench: APB register access, routing, conversion timing,
 * correction and result DMA. Assumes WARMUP_LEN is shortened to 20.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
    import acd_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic pready, pslverr, slow_clock_sel, conv_tick, conv_busy;
    logic dma_wr_valid, dma_wr_ready, saturation_pending;
    logic [IN_CODES-1:0] positive_route, negative_route, exp_route;
    logic [15:0] raw_sample = 16'h0, dma_wr_data, last_data;
    logic [BUF_ADDR_W-1:0] dma_wr_addr, last_addr;
    int n_wr, k, errors = 0, n_checks = 0, sat_cnt = 0;

    acd_top #(.WARMUP_LEN(20)) acd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .positive_route, .negative_route,
        .slow_clock_sel, .conv_tick, .conv_busy, .raw_sample, .dma_wr_valid, .dma_wr_ready,
        .dma_wr_addr, .dma_wr_data, .saturation_pending);
    acd_ram_model acd_ram_model_inst (.pclk, .presetn, .slow, .wr_valid(dma_wr_valid),
        .wr_addr(dma_wr_addr), .wr_data(dma_wr_data), .wr_ready(dma_wr_ready),
        .last_addr, .last_data, .n_wr);

    always #2 pclk = ~pclk;
    always @(posedge pclk) if (saturation_pending === 1'b1) sat_cnt++;

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_wr(input int n);
        k = 0;
        while (n_wr < n && k < 6000) begin
            @(posedge pclk);
            k++;
        end
        `CHK(n_wr, n)
    endtask : wait_wr

    task automatic s_regs;
        apb(0, CONFIG_ADDR, 0);
        `CHK(q, 32'h0000_1800)
        `CHK(positive_route, 12'h001)
        apb(0, GAIN_ADDR, 0);
        `CHK(q, 32'h0000_8000)
        apb(0, OFFSET_ADDR, 0);
        `CHK(q, 32'h0)
        apb(1, RESULT_ADDR, 32'h5555);
        apb(0, RESULT_ADDR, 0);
        `CHK(q, 32'h0)
        apb(0, DMA_STATE_ADDR, 0);
        `CHK(q, 32'h0)
        apb(1, 32'h4000_D0F0, 32'h1);
        `CHK(err, 1'b1)
    endtask : s_regs

    task automatic s_routes;
        // Only defined codes, normal input range assumed
        for (int c = 0; c < 12; c++) begin
            if (c == 6 || c == 7) continue;
            // Reserved bits written as zero
            apb(1, CONFIG_ADDR, (c << 7) | (c << 3) | ((c & 1) << 2));
            #1;
            exp_route = (c < 12 && c != 6 && c != 7) ? (12'h001 << c) : 12'h000;
            `CHK(positive_route, exp_route)
            `CHK(negative_route, exp_route)
            `CHK(slow_clock_sel, c[0])
        end
    endtask : s_routes

    task automatic s_clock;
        for (int i = 0; i < 2; i++) begin
            apb(1, CONFIG_ADDR, i ? 32'h5 : 32'h1);
            for (int j = 0; j < 2; j++) begin
                k = 0;
                do begin
                    @(posedge pclk);
                    k++;
                end while (conv_tick !== 1'b1 && k < 600);
            end
            `CHK(k, i ? 250 : 41)
            apb(1, CONFIG_ADDR, 32'h0);
            #1;
            `CHK(conv_busy, 1'b0)
        end
    endtask : s_clock

    task automatic s_dma;
        raw_sample <= 16'h1234;
        apb(1, OFFSET_ADDR, 32'h100);
        apb(1, BUF_BEGIN_ADDR, 32'h100);
        apb(1, BUF_SIZE_ADDR, 32'h2);
        apb(1, DMA_CTRL_ADDR, 32'h1);
        apb(0, DMA_STATE_ADDR, 0);
        `CHK(q, 32'h1)
        apb(0, DMA_CTRL_ADDR, 0);
        `CHK(q, 32'h0)
        apb(1, CONFIG_ADDR, 32'h1);
        wait_wr(1);
        `CHK(k >= 2644 && k < 2700, 1'b1)
        `CHK(last_data, 16'h1300)
        `CHK(last_addr, 14'h100)
        wait_wr(2);
        `CHK(k, 1312)
        `CHK(last_addr, 14'h102)
        apb(0, RESULT_ADDR, 0);
        `CHK(q, 32'h1300)
        repeat (1400) @(posedge pclk);
        apb(0, DMA_STATE_ADDR, 0);
        `CHK(q, 32'h2)
        `CHK(n_wr, 2)
        apb(1, DMA_CTRL_ADDR, 32'h10);
        apb(0, DMA_STATE_ADDR, 0);
        `CHK(q, 32'h0)
        apb(0, DMA_CTRL_ADDR, 0);
        `CHK(q, 32'h0)
    endtask : s_dma

    task automatic s_sat;
        slow <= 1'b1;
        raw_sample <= 16'h7E00;
        apb(1, OFFSET_ADDR, 32'h0);
        apb(1, GAIN_ADDR, 32'hFFFF);
        apb(1, BUF_SIZE_ADDR, 32'h1);
        apb(1, DMA_CTRL_ADDR, 32'h3);
        wait_wr(3);
        `CHK(last_data, 16'h7FFF)
        `CHK(sat_cnt, 1)
        raw_sample <= 16'h8000;
        apb(1, OFFSET_ADDR, 32'h8000);
        apb(1, CONFIG_ADDR, 32'h1);
        wait_wr(4);
        `CHK(k > 2000 && k < 2700, 1'b1)
        `CHK(last_data, 16'h8000)
        `CHK(last_addr, 14'h100)
        `CHK(sat_cnt, 2)
        raw_sample <= 16'h12FF;
        apb(1, GAIN_ADDR, 32'h8000);
        apb(1, OFFSET_ADDR, 32'h0);
        apb(1, CONFIG_ADDR, 32'h2001);
        wait_wr(5);
        `CHK(k > 5200 && k < 5300, 1'b1)
        wait_wr(6);
        `CHK(k, 2624)
        `CHK(last_data, 16'h1200)
        apb(1, CONFIG_ADDR, 32'h0);
    endtask : s_sat

    task automatic summarize;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_routes();
        s_clock();
        s_dma();
        s_sat();
        summarize();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        summarize();
    end
endmodule : tb
